//--- verilog/rrc_ctrl.sv
// Channel redundancy control and refresh-time estimate of a bus station
// How it works
// - Distance term 10 ns per metre, per port
// - Module points counted in 16-point units
// - Cable fault or lost recognised subunit is error
// - Continue only when both error actions run
// - Loop mode carries traffic on primary loop
// - One loop broken: move to intact loop
// - Both loops broken: split into two chains
// - Flag switchover; controller checks and clears it
// - After switchover, switches and actions decide
// - Loop switching needs run, shutdown off, loop on
// - After split no further recovery, outputs unassured
// - Chain error: isolate stations past the break
// - Chain loop-back needs run, shutdown off, loop off
`timescale 1ns/100ps
module rrc_ctrl
(
	input  wire logic                             i_clk,
	input  wire logic                             i_rst_n,
	input  wire logic                             i_io_err_run,
	input  wire logic                             i_sub_err_run,
	input  wire rrc_pkg::rrc_pins_t               i_pins,
	input  wire logic                             i_switch_clr,
	input  wire logic                             i_cfg_we,
	input  wire logic [rrc_pkg::RRC_IDX_W-1:0]    i_cfg_idx,
	input  wire rrc_pkg::rrc_entry_t              i_cfg_data,
	input  wire logic                             i_est_start,
	output      rrc_pkg::rrc_path_t               o_path,
	output      logic                             o_sys_run,
	output      logic                             o_chan_err,
	output      logic                             o_switched,
	output      logic                             o_data_loss,
	output      logic                             o_out_assured,
	output      logic [rrc_pkg::RRC_STATIONS-1:0] o_isolate,
	output      logic [rrc_pkg::RRC_IDX_W-1:0]    o_terminal,
	output      rrc_pkg::rrc_est_t                o_est [rrc_pkg::RRC_PORTS],
	output      logic                             o_est_busy,
	output      logic                             o_est_done
);
	import rrc_pkg::*;

	localparam int PINS_W = $bits(rrc_pins_t);

	// Highest set station index, zero when none
	function automatic logic [RRC_IDX_W-1:0] top_idx(input logic [RRC_STATIONS-1:0] m);
		logic [RRC_IDX_W-1:0] r;
		r = '0;
		for (int i = 0; i < RRC_STATIONS; i++)
			if (m[i])
				r = RRC_IDX_W'(i);
		return r;
	endfunction

	// Pin synchronisers with agreement filter
	logic [PINS_W-1:0] s1_reg;
	logic [PINS_W-1:0] s2_reg;
	logic [PINS_W-1:0] s3_reg;
	logic [PINS_W-1:0] flt_reg;
	rrc_pins_t         pins;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			s1_reg <= RRC_PINS_RST;
			s2_reg <= RRC_PINS_RST;
			s3_reg <= RRC_PINS_RST;
		end
		else
		begin
			s1_reg <= i_pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	for (genvar g = 0; g < PINS_W; g++)
	begin : g_flt
		always_ff @(posedge i_clk)
		begin
			if (!i_rst_n)
				flt_reg[g] <= RRC_PINS_RST[g];
			else if (s2_reg[g] == s3_reg[g])
				flt_reg[g] <= s2_reg[g];
		end
	end

	assign pins = flt_reg;

	// Reachability runs outward from the main unit
	logic [RRC_STATIONS-1:0] reach;
	logic [RRC_STATIONS-1:0] recog_reg;
	logic [RRC_STATIONS-1:0] lost;
	logic [RRC_STATIONS-1:0] cut_off;

	assign reach[0] = pins.station_ok[0];
	for (genvar g = 1; g < RRC_STATIONS; g++)
	begin : g_reach
		assign reach[g] = reach[g-1] & pins.station_ok[g];
	end

	// Only stations seen before can be lost
	assign lost    = recog_reg & ~pins.station_ok;
	assign cut_off = recog_reg & ~reach;

	// Settings decode
	logic run_cfg;
	logic loop_sw_en;
	logic chain_lb_en;
	logic power_lost;
	logic cable_fault;
	logic chan_err;

	rrc_state_t state_reg;
	rrc_state_t state_next;
	logic [2:0] settle_reg;

	assign run_cfg     = i_io_err_run & i_sub_err_run;
	assign loop_sw_en  = run_cfg & ~pins.sd_sw & pins.loop_sw;
	assign chain_lb_en = run_cfg & ~pins.sd_sw & ~pins.loop_sw;
	assign power_lost  = |lost;
	assign cable_fault = (state_reg == RRC_ST_PRI && !pins.pri_ok)
		|| (state_reg == RRC_ST_SEC && !pins.sec_ok);
	assign chan_err    = cable_fault | power_lost;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			RRC_ST_INIT:
				if (settle_reg == 3'(RRC_SETTLE_CYC))
					state_next = pins.loop_sw ? RRC_ST_PRI : RRC_ST_CHAIN;
			RRC_ST_PRI:
				if (chan_err)
				begin
					if (!loop_sw_en)
						state_next = RRC_ST_STOP;
					else if (pins.sec_ok && !power_lost)
						state_next = RRC_ST_SEC;
					else
						state_next = RRC_ST_SPLIT;
				end
			RRC_ST_SEC:
				if (chan_err)
				begin
					if (!loop_sw_en)
						state_next = RRC_ST_STOP;
					else if (pins.pri_ok && !power_lost)
						state_next = RRC_ST_PRI;
					else
						state_next = RRC_ST_SPLIT;
				end
			// Later breaks are not recovered here
			RRC_ST_SPLIT:
				if (chan_err && !run_cfg)
					state_next = RRC_ST_STOP;
			RRC_ST_CHAIN:
				if (chan_err && !chain_lb_en)
					state_next = RRC_ST_STOP;
			RRC_ST_STOP:
				state_next = RRC_ST_STOP;
			default:
				state_next = RRC_ST_STOP;
		endcase
	end

	logic      enter_switch;
	logic      enter_split;
	rrc_path_t path_next;

	assign enter_switch = (state_next == RRC_ST_SEC || state_next == RRC_ST_SPLIT
		|| state_next == RRC_ST_PRI) && state_next != state_reg
		&& state_reg != RRC_ST_INIT;
	assign enter_split  = state_next == RRC_ST_SPLIT && state_reg != RRC_ST_SPLIT;

	always_comb
	begin
		unique case (state_next)
			RRC_ST_PRI:   path_next = RRC_PATH_PRI;
			RRC_ST_SEC:   path_next = RRC_PATH_SEC;
			RRC_ST_SPLIT: path_next = RRC_PATH_SPLIT;
			RRC_ST_CHAIN: path_next = RRC_PATH_CHAIN;
			default:      path_next = RRC_PATH_NONE;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			state_reg  <= RRC_ST_INIT;
			settle_reg <= '0;
			recog_reg  <= '0;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg == RRC_ST_INIT)
				settle_reg <= settle_reg + 3'h1;
			recog_reg <= recog_reg | pins.station_ok;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_switched  <= 1'b0;
			o_data_loss <= 1'b0;
		end
		else
		begin
			o_switched  <= enter_switch | (o_switched & ~i_switch_clr);
			o_data_loss <= enter_split | (o_data_loss & ~i_switch_clr);
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_path        <= RRC_PATH_NONE;
			o_sys_run     <= 1'b1;
			o_chan_err    <= 1'b0;
			o_out_assured <= 1'b1;
		end
		else
		begin
			o_path        <= path_next;
			o_sys_run     <= state_next != RRC_ST_STOP;
			o_chan_err    <= chan_err;
			// Stays low after a split, even if the system later stops
			o_out_assured <= o_out_assured && state_next != RRC_ST_SPLIT;
		end
	end

	// Chain loop-back: last reachable station ends the chain
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_isolate  <= '0;
			o_terminal <= '0;
		end
		else if (state_reg == RRC_ST_CHAIN && chain_lb_en)
		begin
			o_isolate  <= cut_off;
			o_terminal <= top_idx(recog_reg & reach);
		end
	end

	// Refresh estimate: scan the station table once per request
	rrc_entry_t               ent;
	logic [RRC_IDX_W-1:0]     idx_reg;
	logic                     rd_vld_reg;
	logic                     rd_last_reg;
	logic                     fin_reg;
	logic                     est_go;
	logic [RRC_DIST_W-1:0]    dist_term;
	logic [RRC_UNIT_W-1:0]    unit_term;
	rrc_est_t                 acc_reg [RRC_PORTS];

	assign est_go    = i_est_start & ~o_est_busy;
	assign dist_term = RRC_DIST_W'(ent.len_m * RRC_DIST_W'(RRC_NS_PER_M));
	assign unit_term = rrc_units(ent.in_pts) + rrc_units(ent.out_pts);

	rrc_cfg_mem u_mem
	(
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_we    (i_cfg_we),
		.i_waddr (i_cfg_idx),
		.i_wdata (i_cfg_data),
		.i_raddr (idx_reg),
		.o_rdata (ent)
	);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_est_busy  <= 1'b0;
			idx_reg     <= '0;
			rd_vld_reg  <= 1'b0;
			rd_last_reg <= 1'b0;
			fin_reg     <= 1'b0;
			o_est_done  <= 1'b0;
		end
		else
		begin
			if (est_go)
				o_est_busy <= 1'b1;
			else if (idx_reg == RRC_LAST_IDX)
				o_est_busy <= 1'b0;
			idx_reg     <= (o_est_busy && !est_go) ? idx_reg + 3'h1 : '0;
			rd_vld_reg  <= o_est_busy;
			rd_last_reg <= o_est_busy && idx_reg == RRC_LAST_IDX;
			fin_reg     <= rd_vld_reg && rd_last_reg;
			o_est_done  <= fin_reg;
		end
	end

	// Each main-unit port keeps its own sums
	for (genvar p = 0; p < RRC_PORTS; p++)
	begin : g_port
		always_ff @(posedge i_clk)
		begin
			if (!i_rst_n || est_go)
				acc_reg[p] <= '0;
			else if (rd_vld_reg && ent.valid && ent.port == 1'(p))
			begin
				acc_reg[p].dist_ns <= acc_reg[p].dist_ns + dist_term;
				acc_reg[p].units   <= acc_reg[p].units + unit_term;
			end
		end

		always_ff @(posedge i_clk)
		begin
			if (!i_rst_n)
				o_est[p] <= '0;
			else if (fin_reg)
				o_est[p] <= acc_reg[p];
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_stop_no_run: assert property (
		(state_reg inside {RRC_ST_PRI, RRC_ST_CHAIN} && chan_err && !run_cfg)
		|=> !o_sys_run && o_path == RRC_PATH_NONE)
		else $error("error without run setting did not stop");

	a_pri_to_sec: assert property (
		(state_reg == RRC_ST_PRI && !pins.pri_ok && pins.sec_ok && !power_lost
		&& loop_sw_en) |=> o_path == RRC_PATH_SEC && o_switched && o_sys_run)
		else $error("primary break did not move to secondary loop");

	a_both_split: assert property (
		(state_reg == RRC_ST_PRI && !pins.pri_ok && !pins.sec_ok && loop_sw_en)
		|=> o_path == RRC_PATH_SPLIT && o_data_loss)
		else $error("double break did not split the loop");

	a_flag_set_wins: assert property (
		(enter_split && i_switch_clr) |=> o_data_loss ##1 (o_data_loss || $past(i_switch_clr)))
		else $error("switchover flag lost to a clear");

	a_sd_blocks_loop: assert property (
		(state_reg inside {RRC_ST_PRI, RRC_ST_SEC} && chan_err && pins.sd_sw)
		|=> !o_sys_run [*2])
		else $error("loop switched with shutdown select on");

	a_split_holds: assert property (
		(o_path == RRC_PATH_SPLIT && o_sys_run) |=> o_path inside {RRC_PATH_SPLIT,
		RRC_PATH_NONE} && !o_out_assured)
		else $error("split recovered or outputs claimed assured");

	a_chain_isolate: assert property (
		(state_reg == RRC_ST_CHAIN && chain_lb_en) |=> o_isolate == $past(cut_off))
		else $error("unreachable stations not isolated");

	a_chain_gate: assert property (
		(state_reg == RRC_ST_CHAIN && chan_err && pins.loop_sw) |=> !o_sys_run)
		else $error("chain loop-back used with loop mode on");

	a_one_scheme: assert property (
		(state_reg == RRC_ST_CHAIN) |=> !(o_path inside {RRC_PATH_SEC, RRC_PATH_SPLIT}))
		else $error("loop switching applied in chain mode");

	a_est_latency: assert property (
		est_go |-> ##11 o_est_done)
		else $error("estimate did not finish in eleven cycles");
endmodule // rrc_ctrl

//--- include/rrc_pkg.sv
// Shared constants, types and helpers of the ring redundancy control block
package rrc_pkg;
	localparam int RRC_STATIONS = 8;
	localparam int RRC_IDX_W    = 3;
	localparam int RRC_PORTS    = 2;
	localparam int RRC_LEN_W    = 12;
	localparam int RRC_PTS_W    = 8;
	localparam int RRC_DIST_W   = 20;
	localparam int RRC_UNIT_W   = 9;

	// Distance term: 1.0 us of refresh per 100 m of cable
	localparam int RRC_DIST_TIME_NS = 1000;
	localparam int RRC_DIST_SPAN_M  = 100;
	localparam int RRC_NS_PER_M     = RRC_DIST_TIME_NS / RRC_DIST_SPAN_M;
	localparam int RRC_PTS_PER_UNIT = 16;

	// Three synchroniser stages plus the agreement filter must fill after reset
	localparam int RRC_SETTLE_CYC = 4;
	localparam logic [RRC_IDX_W-1:0] RRC_LAST_IDX = 3'h7;

	// Switch defaults: shutdown select on, loop mode off
	localparam logic RRC_SD_SW_RST   = 1'b1;
	localparam logic RRC_LOOP_SW_RST = 1'b0;

	typedef struct packed {
		logic                 sd_sw;
		logic                 loop_sw;
		logic                 pri_ok;
		logic                 sec_ok;
		logic [RRC_STATIONS-1:0] station_ok;
	} rrc_pins_t;

	localparam rrc_pins_t RRC_PINS_RST = '{RRC_SD_SW_RST, RRC_LOOP_SW_RST, 1'b0, 1'b0, 8'h00};

	typedef struct packed {
		logic                 valid;
		logic                 port;
		logic [RRC_LEN_W-1:0] len_m;
		logic [RRC_PTS_W-1:0] in_pts;
		logic [RRC_PTS_W-1:0] out_pts;
	} rrc_entry_t;

	typedef struct packed {
		logic [RRC_DIST_W-1:0] dist_ns;
		logic [RRC_UNIT_W-1:0] units;
	} rrc_est_t;

	typedef enum logic [2:0] {
		RRC_PATH_NONE,
		RRC_PATH_PRI,
		RRC_PATH_SEC,
		RRC_PATH_SPLIT,
		RRC_PATH_CHAIN
	} rrc_path_t;

	typedef enum logic [2:0] {
		RRC_ST_INIT,
		RRC_ST_PRI,
		RRC_ST_SEC,
		RRC_ST_SPLIT,
		RRC_ST_CHAIN,
		RRC_ST_STOP
	} rrc_state_t;

	// Point count rounded up to whole 16-point units
	function automatic logic [RRC_UNIT_W-1:0] rrc_units(input logic [RRC_PTS_W-1:0] pts);
		logic [RRC_PTS_W:0] sum;
		sum = {1'b0, pts} + (RRC_PTS_W+1)'(RRC_PTS_PER_UNIT - 1);
		return RRC_UNIT_W'(sum >> 4);
	endfunction
endpackage

//--- verilog/rrc_cfg_mem.sv
// Station table memory with registered read data
`timescale 1ns/100ps
module rrc_cfg_mem
(
	input  wire logic                          i_clk,
	input  wire logic                          i_rst_n,
	input  wire logic                          i_we,
	input  wire logic [rrc_pkg::RRC_IDX_W-1:0] i_waddr,
	input  wire rrc_pkg::rrc_entry_t           i_wdata,
	input  wire logic [rrc_pkg::RRC_IDX_W-1:0] i_raddr,
	output      rrc_pkg::rrc_entry_t           o_rdata
);
	import rrc_pkg::*;

	rrc_entry_t mem_reg [RRC_STATIONS];

	// No reset on the array; entries carry their own valid bit
	always_ff @(posedge i_clk)
	begin
		if (i_we)
			mem_reg[i_waddr] <= i_wdata;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_rdata <= '0;
		else
			o_rdata <= mem_reg[i_raddr];
	end
endmodule // rrc_cfg_mem

//--- tb/rrc_far_model.sv
// Far-side model: neighbouring stations, loop links and switch settings
`timescale 1ns/100ps
module rrc_far_model
(
	input  wire logic                             i_sd_sw,
	input  wire logic                             i_loop_sw,
	input  wire logic                             i_cut_pri,
	input  wire logic                             i_cut_sec,
	input  wire logic [rrc_pkg::RRC_STATIONS-1:0] i_off,
	output      rrc_pkg::rrc_pins_t               o_pins
);
	import rrc_pkg::*;

	// A cut cable drops its link; a powered-down station stops answering
	assign o_pins = '{i_sd_sw, i_loop_sw, ~i_cut_pri, ~i_cut_sec, ~i_off};
endmodule // rrc_far_model

//--- tb/rrc_ctrl_tb.sv
// Self-checking bench of the ring redundancy control block
`timescale 1ns/100ps
module rrc_ctrl_tb;
	import rrc_pkg::*;
	logic                    clk;
	logic                    rst_n;
	logic                    io_run;
	logic                    sub_run;
	logic                    clr;
	logic                    we;
	logic                    go;
	logic                    sd;
	logic                    lp;
	logic                    cut_p;
	logic                    cut_s;
	logic [RRC_IDX_W-1:0]    idx;
	logic [RRC_STATIONS-1:0] off;
	rrc_entry_t              cfg;
	rrc_pins_t               pins;
	rrc_path_t               path;
	logic                    sys_run;
	logic                    chan_err;
	logic                    switched;
	logic                    loss;
	logic                    assured;
	logic                    busy;
	logic                    done;
	logic [RRC_STATIONS-1:0] iso;
	logic [RRC_IDX_W-1:0]    term;
	rrc_est_t                est [RRC_PORTS];
	int                      n_mismatch;
	int                      cmp_count;
	int                      cyc;
	int                      e_len [8] = '{0, 4, 4, 4, 4, 4, 100, 0};
	int                      e_in  [8] = '{0, 32, 32, 32, 32, 32, 17, 0};
	int                      e_out [8] = '{0, 32, 32, 32, 0, 0, 0, 0};

	rrc_far_model far_u (.i_sd_sw(sd), .i_loop_sw(lp), .i_cut_pri(cut_p), .i_cut_sec(cut_s),
		.i_off(off), .o_pins(pins));

	rrc_ctrl dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_io_err_run(io_run),
		.i_sub_err_run(sub_run), .i_pins(pins), .i_switch_clr(clr), .i_cfg_we(we),
		.i_cfg_idx(idx), .i_cfg_data(cfg), .i_est_start(go), .o_path(path),
		.o_sys_run(sys_run), .o_chan_err(chan_err), .o_switched(switched),
		.o_data_loss(loss), .o_out_assured(assured), .o_isolate(iso), .o_terminal(term),
		.o_est(est), .o_est_busy(busy), .o_est_done(done));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic final_report;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			final_report;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Inputs move 1 ns after the edge, away from the sampling instant
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Pins are set during reset; the design waits for its filter after release
	task automatic restart(input logic s, input logic l);
		sd = s;
		lp = l;
		cut_p = 1'b0;
		cut_s = 1'b0;
		off = '0;
		rst_n = 1'b0;
		tick(10);
		rst_n = 1'b1;
		tick(12);
	endtask

	// Bounded wait for a topology change, then compare
	task automatic wait_path(input rrc_path_t exp);
		int k;
		k = 0;
		while (path !== exp && k < 20)
		begin
			tick(1);
			k++;
		end
		chk(path, exp);
	endtask

	initial
	begin
		int k;
		io_run = 1'b1;
		sub_run = 1'b1;
		clr = 1'b0;
		we = 1'b0;
		go = 1'b0;
		idx = '0;
		cfg = '0;
		restart(1'b0, 1'b1);
		wait_path(RRC_PATH_PRI);
		cut_p = 1'b1;
		wait_path(RRC_PATH_SEC);
		chk(switched, 1'b1);
		chk(chan_err, 1'b1);
		chk(loss, 1'b0);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(1);
		chk(switched, 1'b0);
		cut_p = 1'b0;
		cut_s = 1'b1;
		wait_path(RRC_PATH_PRI);
		// Clear held across the split edge: the set must win
		cut_p = 1'b1;
		clr = 1'b1;
		wait_path(RRC_PATH_SPLIT);
		chk(loss, 1'b1);
		chk(switched, 1'b1);
		clr = 1'b0;
		chk(assured, 1'b0);
		chk(sys_run, 1'b1);
		cut_p = 1'b0;
		cut_s = 1'b0;
		tick(10);
		chk(path, RRC_PATH_SPLIT);
		restart(1'b0, 1'b0);
		wait_path(RRC_PATH_CHAIN);
		off = 8'hE0;
		tick(10);
		chk(iso, 8'hE0);
		chk(term, 3'h4);
		chk(path, RRC_PATH_CHAIN);
		chk(sys_run, 1'b1);
		// Each case breaks one enable condition and must stop on a lost station
		// Last case turns loop mode on while in chain mode
		for (int i = 0; i < 5; i++)
		begin
			io_run = (i != 0);
			sub_run = (i != 1);
			restart(i == 2 || i == 3, i == 1 || i == 3);
			lp = lp | (i == 4);
			off = 8'h80;
			tick(10);
			chk(sys_run, 1'b0);
		end
		io_run = 1'b1;
		sub_run = 1'b1;
		we = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			idx = i[RRC_IDX_W-1:0];
			cfg = '{1'(e_in[i] != 0), 1'(i == 6), e_len[i][11:0], e_in[i][7:0], e_out[i][7:0]};
			tick(1);
		end
		we = 1'b0;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		chk(busy, 1'b1);
		k = 0;
		while (done !== 1'b1 && k < 30)
		begin
			tick(1);
			k++;
		end
		// Done is seen after the tenth edge past the start edge
		chk(k, 10);
		chk(est[0].dist_ns, (20 * RRC_DIST_TIME_NS) / RRC_DIST_SPAN_M);
		chk(est[1].dist_ns, (100 * RRC_DIST_TIME_NS) / RRC_DIST_SPAN_M);
		chk(est[0].units, 8 * (32 / RRC_PTS_PER_UNIT));
		chk(est[1].units, 2);
		final_report;
	end
endmodule // rrc_ctrl_tb
